// *** testbench/tb_move_and_return_instr_exec.sv ***
// Self-checking bench for the move and return executor.
// Assumes mre_pkg and mre_exec are compiled first; bench drives inputs on falling edges.
module tb_move_and_return_instr_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import mre_pkg::*;
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin errors++; \
  $display("unexpected %s expected %h seen %h", n, e, s); end end
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] w;
    logic [DATA_W-1:0] ictl;
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic pop;
    logic rdy;
  } mre_note_type;
  logic clk, reset_n, instr_valid, instr_ready, stack_pop, status_write, m_rdy;
  mre_instr_type instr;
  logic [PC_W-1:0] stack_top, pc;
  logic [DATA_W-1:0] working_register, interrupt_control_reg;
  mre_fwrite_type file_write;
  int errors, num_checks;
  logic [31:0] lfsr_state = 32'h0361;
  mre_note_type notes[$];
  mre_note_type m;
  mre_exec mre_exec_inst(.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .stack_top(stack_top), .stack_pop(stack_pop), .pc(pc),
    .working_register(working_register), .interrupt_control_reg(interrupt_control_reg),
    .file_write(file_write), .status_write(status_write));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task finish_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Offers one instruction and notes what the next cycle must show; a refused offer changes nothing.
  task offer(input logic v, input logic [2:0] op);
    lfsr_state = lfsr_next(lfsr_state);
    instr_valid = v;
    instr.op = mre_op_type'(op);
    instr.file_addr = lfsr_state[6:0];
    instr.literal = lfsr_state[15:8];
    stack_top = lfsr_state[28:16];
    m.rdy = m_rdy;
    m.en = 1'b0;
    m.pop = 1'b0;
    if (v && m_rdy) begin
      m.pc = m.pc + 1'b1;
      case (op)
        1: begin m.en = 1'b1; m.addr = instr.file_addr; m.data = m.w; end
        2: m.w = instr.literal;
        3, 4, 5: begin
          m.pc = stack_top;
          m.pop = 1'b1;
          if (op == 4) m.w = instr.literal;
          if (op == 5) m.ictl[GLOBAL_INT_ENABLE_BIT] = 1'b1;
        end
        default: ;
      endcase
    end
    m_rdy = !m.pop;
    notes.push_back(m);
    @(negedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin clk = 1'b0; forever #4 clk = ~clk; end
  initial begin
    mre_note_type e;
    logic r;
    forever begin
      @(posedge clk);
      r = instr_ready;
      #2;
      if (notes.size() > 0) begin
        e = notes.pop_front();
        `CHK("ready", e.rdy, r)
        `CHK("pc", e.pc, pc)
        `CHK("w", e.w, working_register)
        `CHK("intctl", e.ictl, interrupt_control_reg)
        `CHK("fw_en", e.en, file_write.en)
        if (e.en) `CHK("fw", {e.addr, e.data}, {file_write.addr, file_write.data})
        `CHK("pop", e.pop, stack_pop)
        `CHK("status", 1'b0, status_write)
      end
    end
  end
  initial begin #20000; errors++; finish_test; end
  initial begin
    reset_n = 1'b0; instr_valid = 1'b0; instr = '0; stack_top = '0; errors = 0; num_checks = 0;
    m = '0; m.pc = PC_RESET; m.w = W_RESET; m.ictl = INTCTL_RESET; m_rdy = 1'b1;
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    `CHK("reset", {PC_RESET, W_RESET, INTCTL_RESET, 3'h1}, {pc, working_register, interrupt_control_reg, file_write.en, stack_pop, instr_ready})
    // Each code twice back to back, so every return meets an offer in its second cycle.
    for (int i = 0; i < 16; i++) offer(1'b1, 3'(i / 2));
    $display("test directed done");
    repeat (300) offer(lfsr_state[31] | lfsr_state[30], lfsr_state[19:17]);
    instr_valid = 1'b0;
    @(posedge clk);
    #4;
    $display("test random done");
    finish_test;
  end
endmodule // tb_move_and_return_instr_exec

// *** verilog/mre_exec.sv ***
// Executes no-op, move of W to a file register, literal load and three returns.
// Assumes instructions arrive from logic on clk and the stack top is presented by the core.
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Write W to 7-bit file address, one cycle
// - Load 8-bit literal into W, one cycle
// - Interrupt return pops stack into PC
// - Interrupt return sets global interrupt enable bit
// - Interrupt return takes two cycles
// - Literal return loads literal into W
// - Literal return pops PC, two cycles
// - Subroutine return pops PC, two cycles
module mre_exec
  import mre_pkg::*;
(
  input wire logic clk, // Core instruction clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic instr_valid, // Instruction offered this cycle.
  input wire mre_instr_type instr, // Decoded instruction.
  output logic instr_ready, // Executor can take an instruction.
  input wire logic [PC_W-1:0] stack_top, // Current top of hardware stack.
  output logic stack_pop, // One-cycle pop of the stack.
  output logic [PC_W-1:0] pc, // Program counter.
  output logic [DATA_W-1:0] working_register, // Working register.
  output logic [DATA_W-1:0] interrupt_control_reg, // Interrupt control register.
  output mre_fwrite_type file_write, // File register write strobe.
  output logic status_write // Status flag write, always low here.
);

  typedef enum logic [1:0] {
    MRE_ST_RUN = 2'b01,
    MRE_ST_SECOND = 2'b10
  } mre_state_type;

  mre_state_type state_reg;
  logic [PC_W-1:0] pc_reg;
  logic [DATA_W-1:0] w_reg;
  logic [DATA_W-1:0] intctl_reg;
  mre_fwrite_type fwrite_reg;
  logic pop_reg;
  logic take;

  function automatic logic is_return(input mre_op_type op);
    return op == MRE_OP_RETURN || op == MRE_OP_RETLIT || op == MRE_OP_RETINT;
  endfunction

  // The second cycle of a return is a flush slot, so nothing is taken then.
  assign instr_ready = state_reg == MRE_ST_RUN;
  assign take = instr_valid && instr_ready;
  assign stack_pop = pop_reg;
  assign pc = pc_reg;
  assign working_register = w_reg;
  assign interrupt_control_reg = intctl_reg;
  assign file_write = fwrite_reg;
  assign status_write = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= MRE_ST_RUN;
    end else begin
      case (state_reg)
        MRE_ST_RUN: begin
          if (take && is_return(instr.op)) begin
            state_reg <= MRE_ST_SECOND;
          end
        end
        MRE_ST_SECOND: begin
          state_reg <= MRE_ST_RUN;
        end
        default: begin
          state_reg <= MRE_ST_RUN;
        end
      endcase
    end
  end

  // The stack top is sampled at the issuing edge only.
  // The flush slot never looks at it again, so the core may start its pop then.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_reg <= PC_RESET;
      pop_reg <= 1'b0;
    end else begin
      pop_reg <= take && is_return(instr.op);
      if (take) begin
        if (is_return(instr.op)) begin
          pc_reg <= stack_top;
        end else begin
          pc_reg <= pc_reg + 13'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      w_reg <= W_RESET;
    end else if (take && (instr.op == MRE_OP_LOADLIT || instr.op == MRE_OP_RETLIT)) begin
      w_reg <= instr.literal;
    end
  end

  // Nothing here clears the enable bit.
  // Clearing it on interrupt entry is left to the interrupt logic of the core.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      intctl_reg <= INTCTL_RESET;
    end else if (take && instr.op == MRE_OP_RETINT) begin
      intctl_reg[GLOBAL_INT_ENABLE_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fwrite_reg <= '0;
    end else begin
      // Data is W as it stood before the edge, so a load followed by a move writes the new literal.
      fwrite_reg.en <= take && instr.op == MRE_OP_MOVE_W_TO_FILE;
      fwrite_reg.addr <= instr.file_addr;
      fwrite_reg.data <= w_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Issue control: a return refuses exactly one offer, then issue resumes.
  ret_two_cycle_a: assert property (@(posedge clk) disable iff (!reset_n)
    take && is_return(instr.op) |=> !instr_ready ##1 instr_ready)
    else $error("return did not hold issue for exactly one extra cycle");

  retint_two_cycle_a: assert property (@(posedge clk) disable iff (!reset_n)
    take && instr.op == MRE_OP_RETINT |=> !instr_ready ##1 instr_ready)
    else $error("interrupt return did not take two cycles");

  state_onehot_a: assert property (@(posedge clk) disable iff (!reset_n) $onehot(state_reg))
    else $error("executor state is not one-hot");

  pop_flush_a: assert property (@(posedge clk) disable iff (!reset_n)
    stack_pop |-> !instr_ready)
    else $error("instruction accepted in the flush slot of a return");

  refused_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    instr_valid && !instr_ready |=> $stable(pc_reg) && $stable(w_reg)
      && !fwrite_reg.en && !stack_pop)
    else $error("refused offer changed executor state");

  //////////////////////////////////////////////////////////////////////////////
  // Returns: the stack top is loaded at the issuing edge and popped once.
  ret_pc_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    take && is_return(instr.op) |=> pc_reg == $past(stack_top) && stack_pop)
    else $error("return did not load stack top into pc");

  retint_pc_a: assert property (@(posedge clk) disable iff (!reset_n)
    take && instr.op == MRE_OP_RETINT |=> pc_reg == $past(stack_top) && stack_pop)
    else $error("interrupt return did not load stack top into pc");

  retlit_pc_w_a: assert property (@(posedge clk) disable iff (!reset_n)
    take && instr.op == MRE_OP_RETLIT |=> w_reg == $past(instr.literal) && pc_reg == $past(stack_top))
    else $error("literal return wrong pc or w");

  plain_ret_w_a: assert property (@(posedge clk) disable iff (!reset_n)
    take && instr.op == MRE_OP_RETURN |=> $stable(w_reg) && $stable(intctl_reg))
    else $error("subroutine return changed w or interrupt control");

  pop_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    stack_pop |=> !stack_pop)
    else $error("stack pop lasted more than one cycle");

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt control: only the enable bit moves, and only upward.
  int_enable_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    take && instr.op == MRE_OP_RETINT |=> intctl_reg[GLOBAL_INT_ENABLE_BIT] && $stable(w_reg))
    else $error("interrupt return did not set global enable");

  enable_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
    intctl_reg[GLOBAL_INT_ENABLE_BIT] |=> intctl_reg[GLOBAL_INT_ENABLE_BIT])
    else $error("global enable cleared by the executor");

  intctl_low_a: assert property (@(posedge clk) disable iff (!reset_n)
    $stable(intctl_reg[GLOBAL_INT_ENABLE_BIT-1:0]))
    else $error("interrupt control bits other than the enable changed");

  //////////////////////////////////////////////////////////////////////////////
  // Register moves and the no-op.
  move_file_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    take && instr.op == MRE_OP_MOVE_W_TO_FILE |=> fwrite_reg.en && fwrite_reg.data == $past(w_reg)
      && fwrite_reg.addr == $past(instr.file_addr) && $stable(w_reg))
    else $error("move to file wrote wrong data or address");

  fwrite_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(take && instr.op == MRE_OP_MOVE_W_TO_FILE) |=> !fwrite_reg.en)
    else $error("file write without a move instruction");

  loadlit_w_a: assert property (@(posedge clk) disable iff (!reset_n)
    take && instr.op == MRE_OP_LOADLIT |=> w_reg == $past(instr.literal) && instr_ready)
    else $error("literal load wrong value");

  w_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(take && (instr.op == MRE_OP_LOADLIT || instr.op == MRE_OP_RETLIT))
      |=> $stable(w_reg))
    else $error("w changed without a literal load");

  nop_only_pc_a: assert property (@(posedge clk) disable iff (!reset_n)
    take && instr.op == MRE_OP_NOP |=> pc_reg == $past(pc_reg) + 13'h0001 && $stable(w_reg)
      && $stable(intctl_reg) && !fwrite_reg.en && !stack_pop)
    else $error("no-op changed more than pc");

  pc_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !take |=> $stable(pc_reg))
    else $error("pc moved without an instruction");

  no_status_a: assert property (@(posedge clk) disable iff (!reset_n) !status_write)
    else $error("status written");

  //////////////////////////////////////////////////////////////////////////////
  // Coverage of the main scenarios.
  cov_retint_c: cover property (@(posedge clk) disable iff (!reset_n) take && instr.op == MRE_OP_RETINT);
  cov_retlit_c: cover property (@(posedge clk) disable iff (!reset_n) take && instr.op == MRE_OP_RETLIT);
  cov_move_file_c: cover property (@(posedge clk) disable iff (!reset_n)
    take && instr.op == MRE_OP_LOADLIT ##1 take && instr.op == MRE_OP_MOVE_W_TO_FILE);
  cov_stall_c: cover property (@(posedge clk) disable iff (!reset_n) instr_valid && !instr_ready);
  cov_ret_pair_c: cover property (@(posedge clk) disable iff (!reset_n)
    take && is_return(instr.op) ##2 take && is_return(instr.op));

endmodule // mre_exec

// *** verilog/mre_pkg.sv ***
// Shared constants and carrier types for the move and return executor.
// Assumes a surrounding core that decodes opcodes and owns the stack storage.
package mre_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int GLOBAL_INT_ENABLE_BIT = 7;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic [DATA_W-1:0] INTCTL_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam int ONE_CYCLE = 1;
  localparam int TWO_CYCLES = 2;

  typedef enum logic [2:0] {
    MRE_OP_NOP = 3'h0,
    MRE_OP_MOVE_W_TO_FILE = 3'h1,
    MRE_OP_LOADLIT = 3'h2,
    MRE_OP_RETURN = 3'h3,
    MRE_OP_RETLIT = 3'h4,
    MRE_OP_RETINT = 3'h5
  } mre_op_type;

  typedef struct packed {
    mre_op_type op;
    logic [ADDR_W-1:0] file_addr;
    logic [DATA_W-1:0] literal;
  } mre_instr_type;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mre_fwrite_type;
endpackage
